/* verilog/eao_event_out.sv */
// event and alarm output unit with wishbone register access
`timescale 1ns/10ps
`include "eao_map.svh"
module eao_event_out import eao_pkg::*; #(
	parameter int unsigned TICKS_PER_SEC = `EAO_SEC_NS / `EAO_CLK_NS,
	parameter bit SERVO = 1'b0,
	parameter bit HIGH_DO = 1'b1,
	parameter bit COMM_FITTED = 1'b1,
	parameter bit HEATER_OPT = 1'b1,
	parameter eao_value_type PV_MIN = `EAO_PV_MIN_DFL,
	parameter eao_value_type PV_MAX = `EAO_PV_MAX_DFL
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic signed [15:0] measured_value_i,
	input wire logic signed [15:0] target_value_i,
	input wire logic [6:0] valve_position_i,
	input wire logic self_tuning_flag_i,
	input wire logic hand_control_flag_i,
	input wire logic external_setpoint_flag_i,
	input wire logic slope_run_flag_i,
	input wire logic halt_flag_i,
	input wire logic measured_overflow_i,
	input wire logic external_overflow_i,
	input wire logic heater_open_alarm_i,
	input wire logic heater_circuit_alarm_i,
	input wire logic feedback_pot_fault_i,
	input wire logic [15:0] logic_result_i,
	output logic [2:0] alarm_out_o,
	output logic [12:0] control_out_o
);

	localparam int NCH = `EAO_NUM_CH;

	// ****************************************
	// channel capabilities
	// ****************************************
	function automatic logic ch_present(input int ch);
		// the three highest control channels vanish on reduced variants
		ch_present = !(ch >= NCH - 3 && (!HIGH_DO || SERVO));
	endfunction : ch_present

	function automatic logic mode_legal(input int ch, input eao_mode_type m);
		logic ok;
		ok = 1'b0;
		if (m >= `EAO_M_NONE && m <= `EAO_M_EXT_OVF) begin
			ok = 1'b1;
		end else if (m == `EAO_M_LOGIC) begin
			ok = (ch < 8);
		end else if (m == `EAO_M_DIRECT) begin
			ok = (ch >= 8) && COMM_FITTED;
		end else if (m == `EAO_M_OPT_A || m == `EAO_M_OPT_B) begin
			ok = SERVO || HEATER_OPT;
		end else if (m == `EAO_M_POT) begin
			ok = SERVO;
		end
		mode_legal = ok && ch_present(ch);
	endfunction : mode_legal

	function automatic logic pos_mode(input eao_mode_type m);
		pos_mode = SERVO && (m == `EAO_M_OPT_A || m == `EAO_M_OPT_B);
	endfunction : pos_mode

	function automatic logic limit_mode(input eao_mode_type m);
		limit_mode = (m >= `EAO_M_UPPER_DEVIATION_MODE && m <= `EAO_M_SV_LO) || pos_mode(m);
	endfunction : limit_mode

	function automatic eao_value_type sp_default(input eao_mode_type m);
		eao_value_type v;
		v = `EAO_POS_MIN;
		if (m == `EAO_M_UPPER_DEVIATION_MODE || m == `EAO_M_OUTSIDE_BAND_MODE || m == `EAO_M_INSIDE_BAND_MODE) begin
			v = `EAO_DEV_MAX;
		end else if (m == `EAO_M_DEV_LO) begin
			v = `EAO_DEV_MIN;
		end else if (m == `EAO_M_PV_HI || m == `EAO_M_SV_HI) begin
			v = PV_MAX;
		end else if (m == `EAO_M_PV_LO || m == `EAO_M_SV_LO) begin
			v = PV_MIN;
		end else if (pos_mode(m) && m == `EAO_M_OPT_A) begin
			v = `EAO_POS_MAX;
		end
		sp_default = v;
	endfunction : sp_default

	function automatic eao_count_type band_clamp(input eao_mode_type m, input eao_count_type b);
		eao_count_type top;
		top = pos_mode(m) ? `EAO_BAND_POS_MAX : `EAO_BAND_MAX;
		if (b < `EAO_BAND_MIN) begin
			band_clamp = `EAO_BAND_MIN;
		end else if (b > top) begin
			band_clamp = top;
		end else begin
			band_clamp = b;
		end
	endfunction : band_clamp

	// ****************************************
	// configuration storage
	// ****************************************
	eao_mode_type mode_ff [NCH];
	eao_value_type sp_ff [NCH];
	eao_count_type band_ff [NCH];
	eao_count_type wait_ff [NCH];
	logic [NCH-1:0] sense_ff;
	logic [NCH-1:0] direct_ff;
	logic [NCH-1:0] act_ff;
	logic [NCH-1:0] src_ff;
	logic [NCH-1:0] pin_ff;
	logic [NCH-1:0] nxt_act;
	logic [NCH-1:0] nxt_src;
	eao_count_type cnt_ff [NCH];
	eao_count_type nxt_cnt [NCH];
	logic ack_ff;
	logic [31:0] dat_ff;
	logic [31:0] rd_word;
	logic [31:0] wr_word;
	logic [31:0] sel_mask;
	logic wr_go;
	logic [3:0] adr_ch;
	logic [1:0] adr_reg;
	logic adr_chan;
	logic [31:0] tick_cnt_ff;
	logic tick_ff;

	// ****************************************
	// wishbone slave
	// ****************************************
	assign adr_chan = (wb_adr_i[11:8] == 4'h0);
	assign adr_ch = wb_adr_i[7:4];
	assign adr_reg = wb_adr_i[3:2];
	assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;

	always_comb begin
		rd_word = 32'h0000_0000;
		if (adr_chan) begin
			unique case (adr_reg)
				`EAO_OFS_CFG: begin
					rd_word[4:0] = mode_ff[adr_ch];
					rd_word[`EAO_CFG_SENSE_BIT] = sense_ff[adr_ch];
					rd_word[`EAO_CFG_ACT_BIT] = act_ff[adr_ch];
					rd_word[`EAO_CFG_PRES_BIT] = ch_present(int'(adr_ch));
				end
				`EAO_OFS_SP: rd_word = {{16{sp_ff[adr_ch][15]}}, sp_ff[adr_ch]};
				`EAO_OFS_BAND: rd_word[13:0] = band_ff[adr_ch];
				`EAO_OFS_WAIT: rd_word[13:0] = wait_ff[adr_ch];
			endcase
		end else if (wb_adr_i == `EAO_ADR_STATUS) begin
			rd_word[NCH-1:0] = act_ff;
		end else if (wb_adr_i == `EAO_ADR_DIRECT) begin
			rd_word[NCH-1:0] = direct_ff;
		end
	end

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			sel_mask[b*8 +: 8] = {8{wb_sel_i[b]}};
		end
	end

	// lanes without a select keep their present contents
	assign wr_word = (rd_word & ~sel_mask) | (wb_dat_i & sel_mask);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
			dat_ff <= (wb_cyc_i && wb_stb_i && !ack_ff) ? rd_word : 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	// ****************************************
	// register writes
	// ****************************************
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int c = 0; c < NCH; c++) begin
				mode_ff[c] <= `EAO_M_NONE;
				sp_ff[c] <= `EAO_POS_MIN;
				band_ff[c] <= `EAO_BAND_DFL;
				wait_ff[c] <= `EAO_WAIT_OFF;
			end
			mode_ff[0] <= `EAO_M_UPPER_DEVIATION_MODE;
			sp_ff[0] <= `EAO_DEV_MAX;
			mode_ff[1] <= `EAO_M_DEV_LO;
			sp_ff[1] <= `EAO_DEV_MIN;
			sense_ff <= '0;
		end else if (wr_go && adr_chan && ch_present(int'(adr_ch))) begin
			unique case (adr_reg)
				`EAO_OFS_CFG: begin
					sense_ff[adr_ch] <= wr_word[`EAO_CFG_SENSE_BIT];
					// illegal selections are refused and the old mode stays
					if (mode_legal(int'(adr_ch), wr_word[4:0])
						&& wr_word[4:0] != mode_ff[adr_ch]) begin
						mode_ff[adr_ch] <= wr_word[4:0];
						sp_ff[adr_ch] <= sp_default(wr_word[4:0]);
						band_ff[adr_ch] <= pos_mode(wr_word[4:0]) ?
							`EAO_BAND_POS_DFL : `EAO_BAND_DFL;
					end
				end
				`EAO_OFS_SP: sp_ff[adr_ch] <= wr_word[15:0];
				`EAO_OFS_BAND: band_ff[adr_ch] <= band_clamp(mode_ff[adr_ch], wr_word[13:0]);
				`EAO_OFS_WAIT: begin
					wait_ff[adr_ch] <= (wr_word[13:0] > `EAO_WAIT_MAX) ?
						`EAO_WAIT_MAX : wr_word[13:0];
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			direct_ff <= '0;
		end else if (wr_go && wb_adr_i == `EAO_ADR_DIRECT) begin
			direct_ff <= wr_word[NCH-1:0];
		end
	end

	// ****************************************
	// one second tick
	// ****************************************
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_cnt_ff <= 32'h0000_0000;
			tick_ff <= 1'b0;
		end else if (tick_cnt_ff >= 32'(TICKS_PER_SEC - 1)) begin
			tick_cnt_ff <= 32'h0000_0000;
			tick_ff <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
			tick_ff <= 1'b0;
		end
	end

	// ****************************************
	// per channel event evaluation
	// ****************************************
	eao_wide_type dev;
	eao_wide_type pvx;
	eao_wide_type svx;
	eao_wide_type posx;
	logic any_ovf;

	assign pvx = eao_wide_type'(measured_value_i);
	assign svx = eao_wide_type'(target_value_i);
	assign dev = pvx - svx;
	assign posx = eao_wide_type'({1'b0, valve_position_i});
	assign any_ovf = measured_overflow_i || external_overflow_i;

	for (genvar g = 0; g < NCH; g++) begin : g_ch
		eao_wide_type spx;
		eao_wide_type bw;
		logic on_c;
		logic hold_c;
		logic raw_c;
		logic lim;
		logic waited;

		assign spx = eao_wide_type'(sp_ff[g]);
		assign bw = eao_wide_type'({1'b0, band_ff[g]});
		assign lim = limit_mode(mode_ff[g]);

		always_comb begin
			on_c = 1'b0;
			hold_c = 1'b0;
			raw_c = 1'b0;
			unique case (mode_ff[g])
				`EAO_M_UPPER_DEVIATION_MODE: begin
					on_c = dev > spx;
					hold_c = dev > spx - bw;
				end
				`EAO_M_DEV_LO: begin
					on_c = dev < spx;
					hold_c = dev < spx + bw;
				end
				`EAO_M_OUTSIDE_BAND_MODE: begin
					on_c = dev > spx || dev < -spx;
					hold_c = dev > spx - bw || dev < bw - spx;
				end
				`EAO_M_INSIDE_BAND_MODE: begin
					on_c = dev < spx && dev > -spx;
					hold_c = dev < spx + bw && dev > -spx - bw;
				end
				`EAO_M_PV_HI: begin
					on_c = pvx > spx;
					hold_c = pvx > spx - bw;
				end
				`EAO_M_PV_LO: begin
					on_c = pvx < spx;
					hold_c = pvx < spx + bw;
				end
				`EAO_M_SV_HI: begin
					on_c = svx > spx;
					hold_c = svx > spx - bw;
				end
				`EAO_M_SV_LO: begin
					on_c = svx < spx;
					hold_c = svx < spx + bw;
				end
				`EAO_M_TUNE: raw_c = self_tuning_flag_i;
				`EAO_M_HAND: raw_c = hand_control_flag_i;
				`EAO_M_EXT: raw_c = external_setpoint_flag_i;
				`EAO_M_SLOPE: raw_c = slope_run_flag_i;
				`EAO_M_HALT: raw_c = halt_flag_i;
				`EAO_M_OVF: raw_c = any_ovf;
				`EAO_M_PV_OVF: raw_c = measured_overflow_i;
				`EAO_M_EXT_OVF: raw_c = external_overflow_i;
				`EAO_M_LOGIC: raw_c = logic_result_i[g];
				`EAO_M_DIRECT: raw_c = direct_ff[g];
				`EAO_M_OPT_A: begin
					if (SERVO) begin
						on_c = posx > spx;
						hold_c = posx > spx - bw;
					end else begin
						raw_c = heater_open_alarm_i;
					end
				end
				`EAO_M_OPT_B: begin
					if (SERVO) begin
						on_c = posx < spx;
						hold_c = posx < spx + bw;
					end else begin
						raw_c = heater_circuit_alarm_i;
					end
				end
				`EAO_M_POT: raw_c = feedback_pot_fault_i;
				default: raw_c = 1'b0;
			endcase
		end

		// a limit source stays up until the value backs off by the band
		assign nxt_src[g] = lim ? (src_ff[g] ? hold_c : on_c) : raw_c;

		// elapsed time runs from source onset, so a new wait still counts from there
		assign waited = wait_ff[g] == `EAO_WAIT_OFF || cnt_ff[g] >= wait_ff[g];
		assign nxt_act[g] = ch_present(g) && nxt_src[g]
			&& (!lim || waited || any_ovf);

		always_comb begin
			if (!nxt_src[g] || !lim) begin
				nxt_cnt[g] = `EAO_WAIT_OFF;
			end else if (tick_ff && cnt_ff[g] < `EAO_WAIT_MAX) begin
				nxt_cnt[g] = cnt_ff[g] + 14'h0001;
			end else begin
				nxt_cnt[g] = cnt_ff[g];
			end
		end

		always_ff @(posedge clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				src_ff[g] <= 1'b0;
				act_ff[g] <= 1'b0;
				cnt_ff[g] <= `EAO_WAIT_OFF;
				pin_ff[g] <= 1'b0;
			end else begin
				src_ff[g] <= nxt_src[g];
				act_ff[g] <= nxt_act[g];
				cnt_ff[g] <= nxt_cnt[g];
				// absent channels stay released whatever the sense
				pin_ff[g] <= ch_present(g) && (nxt_act[g] ^ sense_ff[g]);
			end
		end
	end

	assign alarm_out_o = pin_ff[`EAO_NUM_AL-1:0];
	assign control_out_o = pin_ff[NCH-1:`EAO_NUM_AL];

endmodule : eao_event_out

/* verilog/eao_map.svh */
// register map, defaults and timing constants of the event output unit
`ifndef EAO_MAP_SVH
`define EAO_MAP_SVH

`define EAO_NUM_AL 3
`define EAO_NUM_CO 13
`define EAO_NUM_CH 16

// byte addresses: channel n occupies four words at n*16
`define EAO_OFS_CFG 2'h0
`define EAO_OFS_SP 2'h1
`define EAO_OFS_BAND 2'h2
`define EAO_OFS_WAIT 2'h3
`define EAO_ADR_STATUS 12'h100
`define EAO_ADR_DIRECT 12'h104
`define EAO_CFG_SENSE_BIT 8
`define EAO_CFG_ACT_BIT 16
`define EAO_CFG_PRES_BIT 17

`define EAO_DEV_MAX 16'sh61a8
`define EAO_DEV_MIN 16'sh9e58
`define EAO_POS_MAX 16'sh0064
`define EAO_POS_MIN 16'sh0000
`define EAO_PV_MIN_DFL 16'shff38
`define EAO_PV_MAX_DFL 16'sh0578
`define EAO_BAND_DFL 14'h0014
`define EAO_BAND_POS_DFL 14'h0001
`define EAO_BAND_MIN 14'h0001
`define EAO_BAND_MAX 14'h270f
`define EAO_BAND_POS_MAX 14'h0032
`define EAO_WAIT_OFF 14'h0000
`define EAO_WAIT_MAX 14'h270f

`define EAO_SEC_NS 1000000000
`define EAO_CLK_NS 50

`define EAO_M_NONE 5'h01
`define EAO_M_UPPER_DEVIATION_MODE 5'h02
`define EAO_M_DEV_LO 5'h03
`define EAO_M_OUTSIDE_BAND_MODE 5'h04
`define EAO_M_INSIDE_BAND_MODE 5'h05
`define EAO_M_PV_HI 5'h06
`define EAO_M_PV_LO 5'h07
`define EAO_M_SV_HI 5'h08
`define EAO_M_SV_LO 5'h09
`define EAO_M_TUNE 5'h0a
`define EAO_M_HAND 5'h0b
`define EAO_M_EXT 5'h0c
`define EAO_M_SLOPE 5'h0d
`define EAO_M_HALT 5'h0e
`define EAO_M_OVF 5'h0f
`define EAO_M_PV_OVF 5'h10
`define EAO_M_EXT_OVF 5'h11
`define EAO_M_LOGIC 5'h12
`define EAO_M_DIRECT 5'h13
`define EAO_M_OPT_A 5'h14
`define EAO_M_OPT_B 5'h15
`define EAO_M_POT 5'h16

`endif

/* verilog/eao_pkg.sv */
// types shared by the event output unit
`include "eao_map.svh"
package eao_pkg;
	typedef logic [4:0] eao_mode_type;
	typedef logic signed [15:0] eao_value_type;
	typedef logic [13:0] eao_count_type;
	typedef logic signed [17:0] eao_wide_type;
endpackage : eao_pkg

/* test/eao_event_out_assertions.sv */
// port checker for the event output unit
`timescale 1ns/10ps
module eao_event_out_assertions import eao_pkg::*; #(
	parameter bit SERVO = 1'b0,
	parameter bit HIGH_DO = 1'b1
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic signed [15:0] measured_value_i,
	input wire logic signed [15:0] target_value_i,
	input wire logic [2:0] alarm_out_o,
	input wire logic [12:0] control_out_o
);
	// ****************
	// helper state
	// ****************
	// default set points are only known until software writes anything
	logic wr_seen_ff;
	logic clean;
	logic signed [16:0] dev;
	assign dev = measured_value_i - target_value_i;
	assign clean = !wr_seen_ff && !(wb_cyc_i && wb_stb_i && wb_we_i);
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_seen_ff <= 1'b0;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i) begin
			wr_seen_ff <= 1'b1;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_hi_src;
		(clean && dev > 25000) [*2];
	endsequence
	sequence s_hi_hold;
		(clean && alarm_out_o[0] && dev > 24980) [*2];
	endsequence
	a_ack_follows_req: assert property (s_req |=> wb_ack_o) else $error("ack missing");
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_dat_zero_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data leak");
	a_upper_deviation_mode_on: assert property (s_hi_src |=> alarm_out_o[0]) else $error("hi late");
	a_dev_lo_on: assert property ((clean && dev < -25000) [*2] |=> alarm_out_o[1])
		else $error("lo late");
	a_upper_deviation_mode_hold: assert property (s_hi_hold |=> alarm_out_o[0]) else $error("hi dropped");
	a_upper_deviation_mode_off: assert property ((clean && dev <= 24980) [*2] |=> !alarm_out_o[0])
		else $error("hi stuck");
	a_dflt_quiet: assert property (clean [*2] |=> !alarm_out_o[2] && control_out_o == 13'h0)
		else $error("idle channel on");
	a_absent_low: assert property ((SERVO || !HIGH_DO) |-> control_out_o[12:10] == 3'h0)
		else $error("absent pin on");
endmodule : eao_event_out_assertions
bind eao_event_out eao_event_out_assertions #(.SERVO(SERVO), .HIGH_DO(HIGH_DO)) eao_chk_inst (
	.clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
	.measured_value_i, .target_value_i, .alarm_out_o, .control_out_o
);

/* test/eao_relay_load.sv */
// relay and transistor load seen by the output pins
`timescale 1ns/10ps
module eao_relay_load (
	input wire logic clk_i,
	input wire logic [15:0] drive_i,
	output logic [15:0] closed_o
);
	// a contact picks up one cycle after its coil is driven
	always_ff @(posedge clk_i) begin
		closed_o <= drive_i;
	end
endmodule : eao_relay_load

/* test/eao_event_out_tb.sv */
// self-checking bench of the event output unit
`timescale 1ns/10ps
module eao_event_out_tb;
	logic clk_i, nrst_i, cyc, stb, we, ack;
	logic [11:0] adr;
	logic [3:0] sel;
	logic [31:0] wd, rdat, q;
	logic signed [15:0] mv, tv;
	logic [9:0] fl;
	logic [15:0] lr, ct;
	logic [2:0] al;
	logic [12:0] co;
	int n_errors, num_checks, m, i, n;
	logic [11:0] la [5] = '{12'h050, 12'h090, 12'h080, 12'h020, 12'h020};
	int lm [5] = '{18, 18, 19, 19, 22};
	int le [5] = '{18, 1, 19, 14, 14};
	eao_event_out #(.TICKS_PER_SEC(10), .HIGH_DO(1'b0)) eao_event_out_inst (
		.clk_i, .nrst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
		.measured_value_i(mv), .target_value_i(tv), .valve_position_i(7'h32),
		.self_tuning_flag_i(fl[0]), .hand_control_flag_i(fl[1]),
		.external_setpoint_flag_i(fl[2]), .slope_run_flag_i(fl[3]), .halt_flag_i(fl[4]),
		.measured_overflow_i(fl[5]), .external_overflow_i(fl[6]),
		.heater_open_alarm_i(fl[7]), .heater_circuit_alarm_i(fl[8]),
		.feedback_pot_fault_i(fl[9]), .logic_result_i(lr), .alarm_out_o(al),
		.control_out_o(co));
	eao_relay_load eao_relay_load_inst (.clk_i, .drive_i({co, al}), .closed_o(ct));
	always #25 clk_i = ~clk_i;
	// ****************
	// helpers
	// ****************
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic tk(input int k);
		repeat (k) @(posedge clk_i);
	endtask : tk
	// ack is read before this edge's updates land, so no race with the slave
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int c;
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d; sel <= 4'hf;
		c = 0;
		do begin
			@(posedge clk_i);
			c++;
		end while (ack !== 1'b1 && c < 20);
		q = rdat;
		chk(c < 20, 1);
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask : wb
	function automatic logic exp_st(input int k);
		return (k < 15) ? fl[k-10] : (k == 15) ? fl[5] | fl[6] : (k < 18) ? fl[k-11] : fl[k-13];
	endfunction : exp_st
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		wrap_up();
	end
	// ****************
	// main sequence
	// ****************
	initial begin
		clk_i = 0; nrst_i = 0; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wd = 0;
		mv = 0; tv = 0; fl = 0; lr = 0; n_errors = 0; num_checks = 0;
		void'($urandom(32'h41e0));
		tk(2);
		nrst_i <= 1'b1;
		wb(0, 12'h000, 0); chk(q, 32'h20002);
		wb(0, 12'h010, 0); chk(q, 32'h20003);
		wb(0, 12'h004, 0); chk(q, 32'h61a8);
		wb(0, 12'h014, 0); chk(q, 32'hffff9e58);
		wb(0, 12'h008, 0); chk(q, 20);
		wb(0, 12'h00c, 0); chk(q, 0);
		mv <= 16'sd20000; tv <= -16'sd5001 - 16'($urandom_range(0, 3999));
		tk(4); chk(ct[1:0], 2'b01);
		tv <= -16'sd4990; tk(4); chk(ct[0], 1);
		tv <= -16'sd4980; tk(4); chk(ct[0], 0);
		mv <= -16'sd20000; tv <= 16'sd5001 + 16'($urandom_range(0, 3999));
		tk(4); chk(ct[1:0], 2'b10);
		mv <= 0; tv <= 0;
		for (m = 10; m <= 21; m++) if (m != 18 && m != 19) begin
			fl <= 10'($urandom);
			wb(1, 12'h020, m); tk(4); chk(ct[2], exp_st(m));
		end
		wb(1, 12'h020, 32'h10e);
		for (i = 0; i < 2; i++) begin
			fl <= i ? 10'h010 : 10'h000; tk(4); chk(ct[2], !i);
		end
		for (i = 0; i < 5; i++) begin
			wb(1, la[i], lm[i]); wb(0, la[i], 0); chk(q[4:0], le[i]);
		end
		lr <= 16'($urandom); tk(4); chk(ct[5], lr[5]);
		n = $urandom & 32'h100;
		wb(1, 12'h104, n); tk(4); chk(ct[8], n[8]);
		fl <= 10'h001; wb(1, 12'h0f0, 32'ha); tk(4);
		wb(0, 12'h0f0, 0); chk({q[17], ct[15]}, 0);
		wb(1, 12'h030, 4); wb(0, 12'h034, 0); chk(q, 32'h61a8);
		wb(1, 12'h034, 1000); wb(1, 12'h038, 50); wb(1, 12'h030, 4);
		wb(0, 12'h034, 0); chk(q, 1000);
		wb(1, 12'h030, 5); wb(0, 12'h038, 0); chk(q, 20);
		wb(1, 12'h034, 1000); tk(4); chk(ct[3], 1);
		mv <= 16'sd1010; tk(4); chk(ct[3], 1);
		mv <= 16'sd1020 + 16'($urandom_range(0, 1979)); tk(4); chk(ct[3], 0);
		wb(1, 12'h030, 4); wb(1, 12'h034, 1000); tk(4); chk(ct[3], 1);
		mv <= 0; tk(4); chk(ct[3], 0);
		fl <= 0;
		wb(1, 12'h040, 6); wb(1, 12'h044, 500); wb(1, 12'h04c, 2);
		mv <= 16'sd600; tk(8); chk(ct[4], 0);
		mv <= 16'sd400; tk(3); mv <= 16'sd600; tk(8); chk(ct[4], 0);
		n = 0;
		while (ct[4] !== 1'b1 && n < 40) begin
			tk(1);
			n++;
		end
		chk(ct[4], 1);
		mv <= 16'sd481; tk(4); chk(ct[4], 1);
		mv <= 16'sd480; tk(4); chk(ct[4], 0);
		mv <= 16'sd600; fl <= 10'h020; tk(4); chk(ct[4], 1);
		wb(1, 12'h040, 8); wb(0, 12'h044, 0); chk(q, 32'h578);
		tv <= 16'sd1500; tk(4); chk(ct[4], 1);
		wb(1, 12'h200, $urandom); wb(0, 12'h200, 0); chk(q, 0);
		wrap_up();
	end
endmodule : eao_event_out_tb
